/* File: tmsr_pkg.sv */
// constants and types shared by the test mux and status register block
package tmsr_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] TEST_OUTPUT_SELECT_IDX = 8'h4b;
	localparam logic [7:0] DEVICE_STATUS_FLAGS_IDX = 8'h4c;
	localparam logic [7:0] SUPPLY_FAULT_STATUS_IDX = 8'h4d;
	localparam logic [9:0] TEST_OUTPUT_SELECT_ADDR = {TEST_OUTPUT_SELECT_IDX, 2'b00};
	localparam logic [9:0] DEVICE_STATUS_FLAGS_ADDR = {DEVICE_STATUS_FLAGS_IDX, 2'b00};
	localparam logic [9:0] SUPPLY_FAULT_STATUS_ADDR = {SUPPLY_FAULT_STATUS_IDX, 2'b00};
	localparam int ADDR_W = 10;

	// test output select field layout
	localparam int TEST_SEL_LSB = 5;
	localparam int SAMPLE_WIDE_BIT = 3;
	localparam int DP_SEL_LSB = 0;
	localparam logic [7:0] TEST_OUTPUT_SELECT_RST = 8'h00;
	localparam logic [7:0] TEST_OUTPUT_SELECT_WMASK = 8'hef;

	// test pin selector codes
	localparam logic [2:0] TPIN_GROUND = 3'h0;
	localparam logic [2:0] TPIN_AFE = 3'h1;
	localparam logic [2:0] TPIN_CLK_8M = 3'h4;
	localparam logic [2:0] TPIN_ADC_CLK = 3'h5;
	localparam logic [2:0] TPIN_FIRST_DIGITAL = 3'h4;

	// data path source codes
	localparam logic [2:0] DP_DISABLED = 3'h0;
	localparam logic [2:0] DP_LPF = 3'h1;
	localparam logic [2:0] DP_RECT = 3'h2;
	localparam logic [2:0] DP_BPF = 3'h3;
	localparam logic [2:0] DP_ADC = 3'h4;

	// device status fields; codes below are arbitrary neutral values
	localparam logic [1:0] REVISION_CODE = 2'h1;
	localparam logic [1:0] OPTION_CODE = 2'h0;
	localparam logic THRESHOLD_ERR_RST = 1'b1;
	localparam int FAULT_N = 7;

	// sample pacing
	localparam int CLK_MHZ = 40;
	localparam int NARROW_PERIOD_NS = 1000;
	localparam int WIDE_PERIOD_NS = 2000;
	localparam int NARROW_CYC = (NARROW_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int WIDE_CYC = (WIDE_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int PACE_W = 7;
	localparam int SAMPLE_W = 12;
	localparam int NARROW_W = 8;

	typedef enum logic [1:0] {TMSR_BUS_IDLE, TMSR_BUS_RD, TMSR_BUS_WR} tmsr_phase_t;
endpackage

/* File: tmsr_sample_pacer.sv */
// sample tick generator, one tick per narrow or wide sample period
module tmsr_sample_pacer
	import tmsr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic en,
	input wire logic wide,
	output logic tick_q
);
	logic [PACE_W-1:0] cnt_q;
	logic en_q;
	logic wide_q;
	logic cfg_chg;

	// restart the period whenever the format or enable changes
	assign cfg_chg = (en != en_q) || (wide != wide_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= 1'b0;
			wide_q <= 1'b0;
		end else begin
			en_q <= en;
			wide_q <= wide;
		end
	end

	// period counter; wide samples take twice as long
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (!en || cfg_chg) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q == (wide ? PACE_W'(WIDE_CYC - 1) : PACE_W'(NARROW_CYC - 1))) begin
			cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + PACE_W'(1);
			tick_q <= 1'b0;
		end
	end

	narrow_period_a: assert property (@(posedge hclk) disable iff (!hresetn || cfg_chg)
		(tick_q && en && !wide) |-> ##40 tick_q) else $error("narrow sample period wrong");
	wide_period_a: assert property (@(posedge hclk) disable iff (!hresetn || cfg_chg)
		(tick_q && en && wide) |-> ##80 tick_q) else $error("wide sample period wrong");
endmodule

/* File: tmsr_fault_latch.sv */
// sticky fault bits, cleared by a read, a new event wins over the clear
module tmsr_fault_latch
	import tmsr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [FAULT_N-1:0] set,
	input wire logic clr,
	output logic [FAULT_N-1:0] flags_q
);
	// set has priority so an event in the read cycle survives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= '0;
		end else begin
			flags_q <= set | (flags_q & {FAULT_N{~clr}});
		end
	end

	fault_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(|set) |=> ((flags_q & $past(set)) == $past(set))) else $error("fault event lost");
	fault_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(clr && !(|set)) |=> (flags_q == '0)) else $error("fault not cleared on read");
	fault_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!clr && !(|set)) |=> $stable(flags_q)) else $error("fault changed without cause");
endmodule

/* File: tmsr_top.sv */
// test output mux, data path tap and device status registers on ahb-lite
//
// The AHB-Lite slave port was chosen for this implementation.
module tmsr_top
	import tmsr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic clk_8mhz_in,
	input wire logic adc_sample_clk_in,
	input wire logic [SAMPLE_W-1:0] lpf_data,
	input wire logic [SAMPLE_W-1:0] rect_data,
	input wire logic [SAMPLE_W-1:0] bpf_data,
	input wire logic [SAMPLE_W-1:0] adc_data,
	input wire logic early_command_error,
	input wire logic threshold_map_crc_error,
	input wire logic threshold_map_crc_done,
	input wire logic user_nvm_crc_error,
	input wire logic trim_nvm_crc_error,
	input wire logic thermal_shutdown_flag,
	input wire logic io_regulator_overvoltage,
	input wire logic io_regulator_undervoltage,
	input wire logic analog_supply_overvoltage,
	input wire logic analog_supply_undervoltage,
	input wire logic main_supply_overvoltage,
	input wire logic main_supply_undervoltage,
	output logic test_pin_out,
	output logic test_pin_analog_en,
	output logic test_pin_afe_en,
	output logic [SAMPLE_W-1:0] dp_sample,
	output logic dp_sample_valid,
	output logic dp_sample_wide
);
	// a source code is live only for the four defined taps
	function automatic logic src_active(input logic [2:0] code);
		src_active = (code >= DP_LPF) && (code <= DP_ADC);
	endfunction

	// address decode shared by the read and write paths
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_a);
		addr_is = (a == reg_a);
	endfunction

	logic [7:0] test_sel_q;
	logic [7:0] test_sel_d;
	tmsr_phase_t phase_q;
	logic [ADDR_W-1:0] dp_addr_q;
	logic accept;
	logic [ADDR_W-1:0] ap_addr;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic early_err_q;
	logic thr_err_q;
	logic user_err_q;
	logic trim_err_q;
	logic [7:0] dev_stat_val;
	logic [7:0] supply_val;
	logic [FAULT_N-1:0] fault_set;
	logic [FAULT_N-1:0] fault_q;
	logic fault_clr;
	logic [2:0] tpin_code;
	logic [2:0] dp_code;
	logic test_pin_q;
	logic analog_en_q;
	logic afe_en_q;
	logic pace_tick;
	logic [SAMPLE_W-1:0] tap;
	logic [SAMPLE_W-1:0] dp_sample_q;
	logic dp_valid_q;
	logic dp_wide_q;

	// address phase is taken when selected, nonseq or seq, and the bus is ready
	assign accept = hsel && htrans[1] && hready;
	assign ap_addr = haddr[ADDR_W-1:0];

	// bus phase tracking; data phase always completes in one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= TMSR_BUS_IDLE;
			dp_addr_q <= '0;
		end else if (accept) begin
			phase_q <= hwrite ? TMSR_BUS_WR : TMSR_BUS_RD;
			dp_addr_q <= ap_addr;
		end else begin
			phase_q <= TMSR_BUS_IDLE;
		end
	end

	// writes land only on the select register; status writes fall away
	always_comb begin
		test_sel_d = test_sel_q;
		case (phase_q)
			TMSR_BUS_WR: begin
				if (addr_is(dp_addr_q, TEST_OUTPUT_SELECT_ADDR)) begin
					test_sel_d = hwdata[7:0] & TEST_OUTPUT_SELECT_WMASK;
				end
			end
			TMSR_BUS_RD: begin
				test_sel_d = test_sel_q;
			end
			TMSR_BUS_IDLE: begin
				test_sel_d = test_sel_q;
			end
			default: begin
				test_sel_d = test_sel_q;
			end
		endcase
	end

	// select register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_sel_q <= TEST_OUTPUT_SELECT_RST;
		end else begin
			test_sel_q <= test_sel_d;
		end
	end

	// status levels follow their sources, threshold flag only on done; threshold flag starts set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			early_err_q <= 1'b0;
			thr_err_q <= THRESHOLD_ERR_RST;
			user_err_q <= 1'b0;
			trim_err_q <= 1'b0;
		end else begin
			early_err_q <= early_command_error;
			if (threshold_map_crc_done) begin
				thr_err_q <= threshold_map_crc_error;
			end
			user_err_q <= user_nvm_crc_error;
			trim_err_q <= trim_nvm_crc_error;
		end
	end

	// status word; fixed codes sit on top
	assign dev_stat_val = {REVISION_CODE, OPTION_CODE, early_err_q, thr_err_q, user_err_q,
		trim_err_q};
	assign supply_val = {1'b0, fault_q};

	// fault events, ordered as the bit positions of the fault register
	assign fault_set = {thermal_shutdown_flag, io_regulator_overvoltage,
		io_regulator_undervoltage, analog_supply_overvoltage, analog_supply_undervoltage,
		main_supply_overvoltage, main_supply_undervoltage};
	// clear at the edge that takes the read, after the value is captured
	assign fault_clr = accept && !hwrite && addr_is(ap_addr, SUPPLY_FAULT_STATUS_ADDR);

	tmsr_fault_latch u_fault (
		.hclk(hclk),
		.hresetn(hresetn),
		.set(fault_set),
		.clr(fault_clr),
		.flags_q(fault_q)
	);

	// read data captured at address edge, so a write just before is forwarded
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (accept && !hwrite) begin
			if (addr_is(ap_addr, TEST_OUTPUT_SELECT_ADDR)) begin
				hrdata_q <= {24'h00_0000, test_sel_d};
			end else if (addr_is(ap_addr, DEVICE_STATUS_FLAGS_ADDR)) begin
				hrdata_q <= {24'h00_0000, dev_stat_val};
			end else if (addr_is(ap_addr, SUPPLY_FAULT_STATUS_ADDR)) begin
				hrdata_q <= {24'h00_0000, supply_val};
			end else begin
				hrdata_q <= 32'h0000_0000; // unmapped reads return zero, okay
			end
		end
	end

	// zero wait states and never an error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	assign tpin_code = test_sel_q[TEST_SEL_LSB +: 3];
	assign dp_code = test_sel_q[DP_SEL_LSB +: 3];

	// test pin: digital codes drive the pin, analog codes open the analog path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_pin_q <= 1'b0;
			analog_en_q <= 1'b0;
			afe_en_q <= 1'b0;
		end else begin
			analog_en_q <= (tpin_code < TPIN_FIRST_DIGITAL);
			afe_en_q <= (tpin_code == TPIN_AFE);
			case (tpin_code)
				TPIN_CLK_8M: test_pin_q <= clk_8mhz_in;
				TPIN_ADC_CLK: test_pin_q <= adc_sample_clk_in;
				TPIN_GROUND: test_pin_q <= 1'b0;
				default: test_pin_q <= 1'b0; // reserved and analog codes hold low
			endcase
		end
	end

	assign test_pin_out = test_pin_q;
	assign test_pin_analog_en = analog_en_q;
	assign test_pin_afe_en = afe_en_q;

	// pacing runs only for a live tap, so width is ignored otherwise
	tmsr_sample_pacer u_pacer (
		.hclk(hclk),
		.hresetn(hresetn),
		.en(src_active(dp_code)),
		.wide(test_sel_q[SAMPLE_WIDE_BIT]),
		.tick_q(pace_tick)
	);

	// tap select
	always_comb begin
		case (dp_code)
			DP_LPF: tap = lpf_data;
			DP_RECT: tap = rect_data;
			DP_BPF: tap = bpf_data;
			DP_ADC: tap = adc_data;
			default: tap = '0;
		endcase
	end

	// narrow samples keep the top eight bits, right aligned
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_sample_q <= '0;
			dp_valid_q <= 1'b0;
			dp_wide_q <= 1'b0;
		end else begin
			dp_valid_q <= pace_tick && src_active(dp_code);
			dp_wide_q <= test_sel_q[SAMPLE_WIDE_BIT] && src_active(dp_code);
			if (pace_tick && src_active(dp_code)) begin
				if (test_sel_q[SAMPLE_WIDE_BIT]) begin
					dp_sample_q <= tap;
				end else begin
					dp_sample_q <= {4'h0, tap[SAMPLE_W-1 -: NARROW_W]};
				end
			end
		end
	end

	assign dp_sample = dp_sample_q;
	assign dp_sample_valid = dp_valid_q;
	assign dp_sample_wide = dp_wide_q;

	// routing checks; the first edge after reset is skipped since flops still hold reset values
	tpin_clk_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tpin_code == TPIN_CLK_8M) |=> (test_pin_q == $past(clk_8mhz_in)))
		else $error("8 mhz clock not on test pin");
	tpin_adc_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tpin_code == TPIN_ADC_CLK) |=> (test_pin_q == $past(adc_sample_clk_in)))
		else $error("adc clock not on test pin");
	tpin_afe_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tpin_code == TPIN_AFE) |=> (afe_en_q && analog_en_q))
		else $error("afe output not routed");
	tpin_ground_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tpin_code == TPIN_GROUND) |=> (!test_pin_q && !afe_en_q))
		else $error("test pin not grounded");
	tpin_analog_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |-> (analog_en_q == ($past(tpin_code) < TPIN_FIRST_DIGITAL)))
		else $error("analog route flag wrong");
	dp_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!src_active(dp_code) |=> !dp_valid_q) else $error("sample from idle tap");
	dp_fmt_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!src_active(dp_code) |=> !dp_wide_q) else $error("width shown for idle tap");
	dp_narrow_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(dp_valid_q && !dp_wide_q) |-> (dp_sample_q[SAMPLE_W-1:NARROW_W] == 4'h0))
		else $error("narrow sample too wide");
	wake_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 (early_err_q == $past(early_command_error))) else $error("wake error wrong");
	thr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!threshold_map_crc_done |=> $stable(thr_err_q)) else $error("threshold flag moved");
	// status flags track their inputs one cycle behind, threshold flag only when done is set
	thr_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
		threshold_map_crc_done |=> (thr_err_q == $past(threshold_map_crc_error)))
		else $error("threshold flag not loaded");
	user_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 (user_err_q == $past(user_nvm_crc_error))) else $error("user nvm flag wrong");
	trim_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 (trim_err_q == $past(trim_nvm_crc_error))) else $error("trim nvm flag wrong");
	stat_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(accept && !hwrite && addr_is(ap_addr, DEVICE_STATUS_FLAGS_ADDR))
		|=> (hrdata_q == {24'h00_0000, $past(dev_stat_val)}))
		else $error("status read wrong");
	stat_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == TMSR_BUS_WR && !addr_is(dp_addr_q, TEST_OUTPUT_SELECT_ADDR))
		|=> $stable(test_sel_q)) else $error("stray write took effect");
	resv_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hrdata_q[31:8] == 24'h00_0000) && !test_sel_q[4]) else $error("reserved bits set");

	wide_sample_c: cover property (@(posedge hclk) disable iff (!hresetn)
		dp_valid_q && dp_wide_q);
	fault_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
		fault_clr && (|fault_q));
	adc_clk_pin_c: cover property (@(posedge hclk) disable iff (!hresetn)
		(tpin_code == TPIN_ADC_CLK) ##1 test_pin_q);
	narrow_sample_c: cover property (@(posedge hclk) disable iff (!hresetn)
		dp_valid_q && !dp_wide_q);
	early_err_c: cover property (@(posedge hclk) disable iff (!hresetn)
		early_err_q);
endmodule

/* File: tb_test_mux_and_status_regs.sv */
// self-checking bench for the test mux, data path tap and status registers
module tb_test_mux_and_status_regs
	import tmsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic clk8 = 1'b0;
	logic adck = 1'b0;
	logic [SAMPLE_W-1:0] tap [4] = '{default: 12'h0};
	logic early = 1'b0;
	logic thr_err = 1'b0;
	logic thr_done = 1'b0;
	logic user_err = 1'b0;
	logic trim_err = 1'b0;
	logic [FAULT_N-1:0] flt = 7'h0;
	logic pin_out;
	logic pin_an;
	logic pin_afe;
	logic [SAMPLE_W-1:0] dps;
	logic dpv;
	logic dpw;
	int fails = 0;
	int checked = 0;

	// 40 mhz bus clock
	always #12.5 hclk = ~hclk;

	tmsr_top DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.clk_8mhz_in(clk8), .adc_sample_clk_in(adck),
		.lpf_data(tap[0]), .rect_data(tap[1]), .bpf_data(tap[2]), .adc_data(tap[3]),
		.early_command_error(early), .threshold_map_crc_error(thr_err),
		.threshold_map_crc_done(thr_done), .user_nvm_crc_error(user_err),
		.trim_nvm_crc_error(trim_err), .thermal_shutdown_flag(flt[6]),
		.io_regulator_overvoltage(flt[5]), .io_regulator_undervoltage(flt[4]),
		.analog_supply_overvoltage(flt[3]), .analog_supply_undervoltage(flt[2]),
		.main_supply_overvoltage(flt[1]), .main_supply_undervoltage(flt[0]),
		.test_pin_out(pin_out), .test_pin_analog_en(pin_an), .test_pin_afe_en(pin_afe),
		.dp_sample(dps), .dp_sample_valid(dpv), .dp_sample_wide(dpw)
	);

	// register read compare
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t reg got=%h exp=%h", $time, got, exp);
		end
	endtask

	// output port compare
	task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t port got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("counts: checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// unbounded wait for the slave's ready at a rising edge
	task automatic wait_rdy;
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
	endtask

	// one single-word transfer; entered just after a rising edge
	task automatic ahb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {22'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk_sig(32'(hresp), 32'h0);
	endtask

	// expected {analog_en, afe_en, pin} for a test code
	function automatic logic [2:0] pin_exp(input logic [2:0] c, input logic k8, input logic ka);
		return {c < 3'h4, c == TPIN_AFE, (c == TPIN_CLK_8M) ? k8 : ((c == TPIN_ADC_CLK) ? ka : 1'b0)};
	endfunction

	// narrow samples keep the top eight bits, right aligned
	function automatic logic [11:0] smp_exp(input logic [11:0] t, input logic w);
		return w ? t : {4'h0, t[11:4]};
	endfunction

	function automatic logic [31:0] stat_exp(input logic e, input logic t, input logic u,
			input logic r);
		return {24'h0, REVISION_CODE, OPTION_CODE, e, t, u, r};
	endfunction

	// whole run is well under 20000 cycles; give it twice that
	initial begin
		#1000000;
		fails++;
		test_done();
	end

	initial begin
		logic [31:0] d;
		logic [31:0] v;
		int n;
		int m;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		void'($urandom(32'h5aecd5b8));
		@(posedge hclk);
		// reset values, threshold flag set from power-up
		ahb(1'b0, TEST_OUTPUT_SELECT_ADDR, 32'h0, d);
		chk_reg(d, 32'h0);
		ahb(1'b0, DEVICE_STATUS_FLAGS_ADDR, 32'h0, d);
		chk_reg(d, stat_exp(1'b0, 1'b1, 1'b0, 1'b0));
		ahb(1'b0, SUPPLY_FAULT_STATUS_ADDR, 32'h0, d);
		chk_reg(d, 32'h0);
		ahb(1'b1, 10'h3fc, 32'hff, d);
		ahb(1'b0, 10'h3fc, 32'h0, d);
		chk_reg(d, 32'h0);
		$display("test reset values done");
		// select register read back, reserved bit 4 stays zero
		repeat (8) begin
			v = $urandom;
			ahb(1'b1, TEST_OUTPUT_SELECT_ADDR, v, d);
			ahb(1'b0, TEST_OUTPUT_SELECT_ADDR, 32'h0, d);
			chk_reg(d, {24'h0, v[7:0] & TEST_OUTPUT_SELECT_WMASK});
		end
		$display("test select register done");
		// every test code with both levels on the digital sources
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < 2; p++) begin
				clk8 <= p[0];
				adck <= ~p[0];
				ahb(1'b1, TEST_OUTPUT_SELECT_ADDR, {24'h0, c[2:0], 5'h0}, d);
				repeat (3) @(posedge hclk);
				v = 32'(pin_exp(c[2:0], p[0], ~p[0]));
				chk_sig(32'({pin_an, pin_afe, pin_out}), v);
			end
		end
		$display("test pin routing done");
		// status flags follow inputs; threshold flag loads only on done
		repeat (6) begin
			v = $urandom;
			early <= v[0];
			user_err <= v[1];
			trim_err <= v[2];
			thr_err <= v[3];
			thr_done <= 1'b1;
			@(posedge hclk);
			thr_done <= 1'b0;
			thr_err <= ~v[3];
			repeat (2) @(posedge hclk);
			ahb(1'b0, DEVICE_STATUS_FLAGS_ADDR, 32'h0, d);
			chk_reg(d, stat_exp(v[0], v[3], v[1], v[2]));
			ahb(1'b1, DEVICE_STATUS_FLAGS_ADDR, 32'hff, d);
			ahb(1'b0, DEVICE_STATUS_FLAGS_ADDR, 32'h0, d);
			chk_reg(d, stat_exp(v[0], v[3], v[1], v[2]));
		end
		$display("test device status done");
		// one-cycle fault pulses latch, then a read clears them
		for (int b = 0; b < FAULT_N; b++) begin
			flt <= 7'(1 << b);
			@(posedge hclk);
			flt <= 7'h0;
			repeat (2) @(posedge hclk);
			ahb(1'b0, SUPPLY_FAULT_STATUS_ADDR, 32'h0, d);
			chk_reg(d, 32'(1 << b));
			ahb(1'b0, SUPPLY_FAULT_STATUS_ADDR, 32'h0, d);
			chk_reg(d, 32'h0);
		end
		flt <= 7'h7f;
		@(posedge hclk);
		flt <= 7'h0;
		ahb(1'b1, SUPPLY_FAULT_STATUS_ADDR, 32'h0, d);
		ahb(1'b0, SUPPLY_FAULT_STATUS_ADDR, 32'h0, d);
		chk_reg(d, 32'h7f);
		// an event at the very edge that takes the clearing read must survive it
		flt <= 7'h40;
		fork
			ahb(1'b0, SUPPLY_FAULT_STATUS_ADDR, 32'h0, d);
			begin
				@(posedge hclk);
				flt <= 7'h0;
			end
		join
		chk_reg(d, 32'h0);
		ahb(1'b0, SUPPLY_FAULT_STATUS_ADDR, 32'h0, d);
		chk_reg(d, 32'h40);
		$display("test supply faults done");
		// every source code in both widths; unused codes must stay silent
		for (int w = 0; w < 2; w++) begin
			for (int s = 0; s < 8; s++) begin
				for (int i = 0; i < 4; i++) begin
					tap[i] <= 12'($urandom);
				end
				ahb(1'b1, TEST_OUTPUT_SELECT_ADDR, {24'h0, 4'h0, w[0], s[2:0]}, d);
				n = 0;
				do begin
					@(posedge hclk);
					n++;
				end while (dpv !== 1'b1 && n < 200);
				if (s >= 1 && s <= 4) begin
					chk_sig(32'(dps), 32'(smp_exp(tap[s - 1], w[0])));
					chk_sig(32'(dpw), 32'(w));
					m = 0;
					do begin
						@(posedge hclk);
						m++;
					end while (dpv !== 1'b1 && m < 200);
					chk_sig(32'(m), 32'(w ? WIDE_CYC : NARROW_CYC));
				end else begin
					chk_sig(32'(n), 32'd200);
				end
			end
		end
		$display("test data path done");
		test_done();
	end
endmodule
